//--- hdl/gdc_regs.sv
// What this block does
// - Primary dead time is (upper code+1) times 16 ns, 16 to 256 ns.
// - Secondary dead time uses lower code, same (code+1) times 16 ns.
// - Bypass bit one skips that driver's dead time; zero inserts it.
// - Set-point code drives the pedestal-referenced regulation DAC, N/255.
// - Second reference code drives a ground-referenced DAC, N/255.
// - Second reference reaches its pin only in master config 01.
// - Peripheral enable bit 7 enables the primary gate driver.
// - Peripheral enable bit 6 independently enables the secondary driver.
// - Peripheral enable bit 2 turns on the sense pin weak pull-up.
// - Primary steering bit drives primary output alone with open-loop PWM.
// - Secondary steering pulses secondary output only with overvoltage active.
// - Steering PWM period from 8-bit timer period, duty from timer low.
// - Both steering bits set: primary wins, secondary ignored.
// - Digital test enable routes the selected digital signal to test pin.
// - Analog test enable routes analog signal; digital wins if both.
// - Analog only enabled also feeds analog test signals to the ADC.
// - Digital select 000..110 picks the seven internal signals; 111 unused.
// - Digital test enable is bit 7, analog bit 0, both reset zero.
// - Master/slave field: 00 alone, 01 master, 10 slave, 11 semi-master.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module gdc_regs
	import gdc_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [4:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	output logic WB_ACK_O,
	output logic WB_ERR_O,
	input wire logic LOOP_PRIMARY_PWM,
	input wire logic LOOP_SECONDARY_PWM,
	input wire logic OVERVOLT_ACTIVE,
	input wire logic STEER_PWM,
	input wire logic [6:0] DIG_TEST_SIGNALS,
	output logic PRIMARY_GATE_DRIVE,
	output logic SECONDARY_GATE_DRIVE,
	output logic [7:0] SET_POINT_CODE,
	output logic [7:0] SECOND_REFERENCE_CODE,
	output logic REFERENCE_OUTPUT_ENABLE,
	output logic SENSE_PIN_PULLUP_ENABLE,
	output logic TEST_DIGITAL_VALUE,
	output logic TEST_DIGITAL_ROUTE,
	output logic TEST_ANALOG_ROUTE,
	output logic ANALOG_TEST_TO_ADC
);
	typedef struct packed {
		logic [7:0] dead_time;
		logic [7:0] set_point;
		logic [7:0] second_ref;
		logic [7:0] periph_en;
		logic [7:0] block_en;
		logic [7:0] mode;
		logic [31:0] rdata;
		logic ack;
		logic err;
		logic [1:0] in_p1;
		logic [1:0] in_p2;
		logic [1:0] in_s1;
		logic [1:0] in_s2;
		logic [1:0] cmd_prev;
		logic [7:0] p_cnt;
		logic [7:0] s_cnt;
		logic p_out;
		logic s_out;
		logic [2:0] ctl_s1;
		logic [2:0] ctl_s2;
		logic [6:0] dig_s1;
		logic [6:0] dig_s2;
		logic test_val;
		logic test_dig;
		logic test_ana;
		logic to_adc;
		logic ref_en;
	} gdc_state_type;

	gdc_state_type s_q, s_d;
	logic req, wr_lane0, page_ok, hit;
	logic [3:0] woff;
	logic p_cmd, s_cmd;
	logic [7:0] p_delay, s_delay;
	logic [2:0] tsel;

	// Word select: bit 4 chooses the aux page of locally placed registers
	assign woff = {WB_ADR_I[3:2], 2'h0};
	assign req = WB_CYC_I && WB_STB_I && !s_q.ack && !s_q.err;
	assign wr_lane0 = req && WB_WE_I && WB_SEL_I[0];
	assign page_ok = (WB_ADR_I[4] == PAGE_MAIN) || (woff == ADDR_BLOCK_EN)
		|| (woff == ADDR_MODE);
	assign hit = page_ok;

	// Steering picks the gate command; primary steer dominates
	always_comb begin
		if (s_q.periph_en[PE_PSTEER]) begin
			p_cmd = s_q.in_p2[1];
			s_cmd = 1'b0;
		end else if (s_q.periph_en[PE_SSTEER]) begin
			p_cmd = 1'b0;
			s_cmd = s_q.in_p2[1] && s_q.in_s2[1];
		end else begin
			p_cmd = s_q.in_p2[0];
			s_cmd = s_q.in_s2[0];
		end
	end

	// Delay in cycles: (code+1) steps of 16 ns
	assign p_delay = 8'({4'h0, s_q.dead_time[PDT_HI:PDT_LO]} + 8'h01)
		* DT_STEP_C8;
	assign s_delay = 8'({4'h0, s_q.dead_time[SDT_HI:SDT_LO]} + 8'h01)
		* DT_STEP_C8;
	assign tsel = s_q.ctl_s2;

	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		s_d.err = 1'b0;
		// Two-flop synchronisers for all asynchronous inputs
		s_d.in_p1 = {STEER_PWM, LOOP_PRIMARY_PWM};
		s_d.in_p2 = s_q.in_p1;
		s_d.in_s1 = {OVERVOLT_ACTIVE, LOOP_SECONDARY_PWM};
		s_d.in_s2 = s_q.in_s1;
		s_d.dig_s1 = DIG_TEST_SIGNALS;
		s_d.dig_s2 = s_q.dig_s1;
		s_d.ctl_s1 = s_q.block_en[AB_TSEL_HI:AB_TSEL_LO];
		s_d.ctl_s2 = s_q.ctl_s1;
		s_d.cmd_prev = {s_cmd, p_cmd};
		// Bus slave: one-cycle answer, error on unmapped word
		if (req) begin
			s_d.ack = hit;
			s_d.err = !hit;
			s_d.rdata = 32'h0;
			if (WB_ADR_I[4] == PAGE_MAIN) begin
				unique case (woff)
				ADDR_DEAD_TIME: s_d.rdata[7:0] = s_q.dead_time;
				ADDR_SET_POINT: s_d.rdata[7:0] = s_q.set_point;
				ADDR_SECOND_REF: s_d.rdata[7:0] = s_q.second_ref;
				default: s_d.rdata[7:0] = s_q.periph_en;
				endcase
			end else if (woff == ADDR_BLOCK_EN) begin
				s_d.rdata[7:0] = s_q.block_en;
			end else begin
				s_d.rdata[7:0] = s_q.mode;
			end
		end
		if (wr_lane0 && hit) begin
			if (WB_ADR_I[4] == PAGE_MAIN) begin
				unique case (woff)
				ADDR_DEAD_TIME: s_d.dead_time = WB_DAT_I[7:0];
				ADDR_SET_POINT: s_d.set_point = WB_DAT_I[7:0];
				ADDR_SECOND_REF: s_d.second_ref = WB_DAT_I[7:0];
				default: s_d.periph_en = WB_DAT_I[7:0] & MASK_PERIPH_EN;
				endcase
			end else if (woff == ADDR_BLOCK_EN) begin
				s_d.block_en = WB_DAT_I[7:0] & MASK_BLOCK_EN;
			end else begin
				s_d.mode = WB_DAT_I[7:0] & MASK_MODE;
			end
		end
		// Primary driver: delay rising edge only, drop at once
		if (!s_q.periph_en[PE_PRI_EN] || !p_cmd) begin
			s_d.p_out = 1'b0;
			s_d.p_cnt = 8'h00;
		end else if (s_q.periph_en[PE_PBYP]) begin
			s_d.p_out = 1'b1;
		end else if (!s_q.p_out) begin
			s_d.p_cnt = s_q.p_cnt + 8'h01;
			s_d.p_out = (s_q.p_cnt + 8'h01) >= p_delay;
		end
		// Secondary driver mirrors the primary
		if (!s_q.periph_en[PE_SEC_EN] || !s_cmd) begin
			s_d.s_out = 1'b0;
			s_d.s_cnt = 8'h00;
		end else if (s_q.periph_en[PE_SBYP]) begin
			s_d.s_out = 1'b1;
		end else if (!s_q.s_out) begin
			s_d.s_cnt = s_q.s_cnt + 8'h01;
			s_d.s_out = (s_q.s_cnt + 8'h01) >= s_delay;
		end
		// Test pin routing; digital wins over analog
		s_d.test_dig = s_q.block_en[AB_DIGOE];
		s_d.test_ana = s_q.block_en[AB_ANAOE] && !s_q.block_en[AB_DIGOE];
		s_d.to_adc = s_q.block_en[AB_ANAOE] && !s_q.block_en[AB_DIGOE];
		// Code 111 has no source, so it reads as low
		if (tsel == TSEL_UNUSED) begin
			s_d.test_val = 1'b0;
		end else begin
			s_d.test_val = s_q.dig_s2[tsel];
		end
		s_d.ref_en = s_q.mode[MS_HI:MS_LO] == MS_MASTER;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_q <= '0;
			s_q.dead_time <= RST_DEAD_TIME;
			s_q.set_point <= RST_SET_POINT;
			s_q.second_ref <= RST_SECOND_REF;
			s_q.periph_en <= RST_PERIPH_EN;
			s_q.block_en <= RST_BLOCK_EN;
			s_q.mode <= RST_MODE;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops
	assign WB_DAT_O = s_q.rdata;
	assign WB_ACK_O = s_q.ack;
	assign WB_ERR_O = s_q.err;
	assign PRIMARY_GATE_DRIVE = s_q.p_out;
	assign SECONDARY_GATE_DRIVE = s_q.s_out;
	assign SET_POINT_CODE = s_q.set_point;
	assign SECOND_REFERENCE_CODE = s_q.second_ref;
	assign REFERENCE_OUTPUT_ENABLE = s_q.ref_en;
	assign SENSE_PIN_PULLUP_ENABLE = s_q.periph_en[PE_PULLUP];
	assign TEST_DIGITAL_VALUE = s_q.test_val;
	assign TEST_DIGITAL_ROUTE = s_q.test_dig;
	assign TEST_ANALOG_ROUTE = s_q.test_ana;
	assign ANALOG_TEST_TO_ADC = s_q.to_adc;

	property p_primary_off;
		@(posedge CLK) disable iff (RST)
		!s_q.periph_en[PE_PRI_EN] |=> !PRIMARY_GATE_DRIVE;
	endproperty
	a_primary_off: assert property (p_primary_off)
		else $error("primary drive high while disabled");

	property p_secondary_off;
		@(posedge CLK) disable iff (RST)
		!s_q.periph_en[PE_SEC_EN] |=> !SECONDARY_GATE_DRIVE;
	endproperty
	a_secondary_off: assert property (p_secondary_off)
		else $error("secondary drive high while disabled");

	property p_dead_min;
		@(posedge CLK) disable iff (RST)
		$rose(PRIMARY_GATE_DRIVE) && !s_q.periph_en[PE_PBYP]
			|-> $past(p_cmd, DT_STEP_CYC);
	endproperty
	a_dead_min: assert property (p_dead_min)
		else $error("primary turned on before dead time");

	property p_bypass;
		@(posedge CLK) disable iff (RST)
		s_q.periph_en[PE_PBYP] && s_q.periph_en[PE_PRI_EN] && p_cmd
			|=> PRIMARY_GATE_DRIVE;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass did not pass edge at once");

	property p_fall;
		@(posedge CLK) disable iff (RST)
		!p_cmd |=> !PRIMARY_GATE_DRIVE;
	endproperty
	a_fall: assert property (p_fall)
		else $error("turn-off was delayed");

	property p_steer_dom;
		@(posedge CLK) disable iff (RST)
		s_q.periph_en[PE_PSTEER] |=> !SECONDARY_GATE_DRIVE;
	endproperty
	a_steer_dom: assert property (p_steer_dom)
		else $error("secondary drove during primary steering");

	property p_ref_route;
		@(posedge CLK) disable iff (RST)
		REFERENCE_OUTPUT_ENABLE |-> $past(s_q.mode[MS_HI:MS_LO]) == MS_MASTER;
	endproperty
	a_ref_route: assert property (p_ref_route)
		else $error("reference routed outside master mode");

	property p_test_pri;
		@(posedge CLK) disable iff (RST)
		TEST_DIGITAL_ROUTE |-> !TEST_ANALOG_ROUTE && !ANALOG_TEST_TO_ADC;
	endproperty
	a_test_pri: assert property (p_test_pri)
		else $error("analog routed while digital enabled");

	property p_ack_once;
		@(posedge CLK) disable iff (RST)
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack held two cycles");

	// Secondary driver checks mirror the primary ones
	property p_sec_dead_min;
		@(posedge CLK) disable iff (RST)
		$rose(SECONDARY_GATE_DRIVE) && !s_q.periph_en[PE_SBYP]
			|-> $past(s_cmd, DT_STEP_CYC);
	endproperty
	a_sec_dead_min: assert property (p_sec_dead_min)
		else $error("secondary turned on before dead time");

	property p_sec_bypass;
		@(posedge CLK) disable iff (RST)
		s_q.periph_en[PE_SBYP] && s_q.periph_en[PE_SEC_EN] && s_cmd
			|=> SECONDARY_GATE_DRIVE;
	endproperty
	a_sec_bypass: assert property (p_sec_bypass)
		else $error("secondary bypass did not pass edge at once");

	property p_sec_fall;
		@(posedge CLK) disable iff (RST)
		!s_cmd |=> !SECONDARY_GATE_DRIVE;
	endproperty
	a_sec_fall: assert property (p_sec_fall)
		else $error("secondary turn-off was delayed");

	// Open-loop steering: the timer PWM alone commands the primary
	property p_steer_pri;
		@(posedge CLK) disable iff (RST)
		s_q.periph_en[PE_PSTEER] && s_q.periph_en[PE_PRI_EN]
			&& s_q.periph_en[PE_PBYP] && s_q.in_p2[1]
			|=> PRIMARY_GATE_DRIVE;
	endproperty
	a_steer_pri: assert property (p_steer_pri)
		else $error("primary steering PWM did not reach the gate");

	property p_steer_sec;
		@(posedge CLK) disable iff (RST)
		s_q.periph_en[PE_SSTEER] && !s_q.in_s2[1] |=> !SECONDARY_GATE_DRIVE;
	endproperty
	a_steer_sec: assert property (p_steer_sec)
		else $error("secondary steered without overvoltage");

	property p_unused_sel;
		@(posedge CLK) disable iff (RST)
		tsel == TSEL_UNUSED |=> !TEST_DIGITAL_VALUE;
	endproperty
	a_unused_sel: assert property (p_unused_sel)
		else $error("unused test select drove the test value");

	c_write: cover property (@(posedge CLK) wr_lane0 && hit);
	c_p_on: cover property (@(posedge CLK) $rose(PRIMARY_GATE_DRIVE));
	c_s_steer: cover property (@(posedge CLK)
		s_q.periph_en[PE_SSTEER] && SECONDARY_GATE_DRIVE);
	c_err: cover property (@(posedge CLK) WB_ERR_O);
	c_s_on: cover property (@(posedge CLK) $rose(SECONDARY_GATE_DRIVE));
endmodule
`default_nettype wire

//--- include/gdc_pkg.sv
package gdc_pkg;
	// Register word offsets (byte addresses)
	localparam logic [3:0] ADDR_DEAD_TIME = 4'h0;
	localparam logic [3:0] ADDR_SET_POINT = 4'h4;
	localparam logic [3:0] ADDR_SECOND_REF = 4'h8;
	localparam logic [3:0] ADDR_PERIPH_EN = 4'hC;
	localparam logic [3:0] ADDR_BLOCK_EN = 4'h0;
	localparam logic [3:0] ADDR_MODE = 4'h4;
	localparam logic [0:0] PAGE_MAIN = 1'h0;
	localparam logic [0:0] PAGE_AUX = 1'h1;
	// Reset values
	localparam logic [7:0] RST_DEAD_TIME = 8'h00;
	localparam logic [7:0] RST_SET_POINT = 8'h00;
	localparam logic [7:0] RST_SECOND_REF = 8'h00;
	localparam logic [7:0] RST_PERIPH_EN = 8'h00;
	localparam logic [7:0] RST_BLOCK_EN = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	// Field positions
	localparam int PDT_HI = 7;
	localparam int PDT_LO = 4;
	localparam int SDT_HI = 3;
	localparam int SDT_LO = 0;
	localparam int PE_PRI_EN = 7;
	localparam int PE_SEC_EN = 6;
	localparam int PE_PBYP = 5;
	localparam int PE_SBYP = 4;
	localparam int PE_PULLUP = 2;
	localparam int PE_PSTEER = 1;
	localparam int PE_SSTEER = 0;
	localparam int AB_DIGOE = 7;
	localparam int AB_TSEL_HI = 6;
	localparam int AB_TSEL_LO = 4;
	localparam int AB_ANAOE = 0;
	localparam int MS_HI = 7;
	localparam int MS_LO = 6;
	// Writable masks; unimplemented bits read zero
	localparam logic [7:0] MASK_PERIPH_EN = 8'hF7;
	localparam logic [7:0] MASK_BLOCK_EN = 8'hFB;
	localparam logic [7:0] MASK_MODE = 8'hE8;
	localparam logic [1:0] MS_MASTER = 2'h1;
	// Dead time step and clock
	localparam int CLK_PERIOD_PS = 4000;
	localparam int DT_STEP_PS = 16000;
	localparam int DT_STEP_CYC = DT_STEP_PS / CLK_PERIOD_PS;
	localparam logic [7:0] DT_STEP_C8 = 8'(DT_STEP_CYC);
	typedef enum logic [2:0] {
		TSEL_DESAT, TSEL_PWM_MONO, TSEL_PWM_OSC, TSEL_TMR_MATCH,
		TSEL_OVERVOLT, TSEL_SW_FREQ, TSEL_ONESHOT, TSEL_UNUSED
	} gdc_test_sel_type;
endpackage

//--- sim/gdc_loop_model.sv
`timescale 1ns/100ps
`default_nettype none
// Timer side of the steering PWM; a free counter so duty is real
module gdc_loop_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] period,
	input wire logic [7:0] duty,
	output logic steer_pwm
);
	logic [7:0] cnt_q;
	// Wraps at the timer period
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cnt_q <= 8'h00;
		else if (cnt_q >= period)
			cnt_q <= 8'h00;
		else
			cnt_q <= cnt_q + 8'h01;
	end
	// High while below the low-byte duty
	assign steer_pwm = (cnt_q < duty);
endmodule
`default_nettype wire

//--- sim/gdc_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module gdc_regs_bench import gdc_pkg::*;;
	logic clk, rst, we, cyc, stb, ack, err, lp, ls, ov, steer;
	logic pg, sg, refo, pull, tval, tdr, tar, tadc;
	logic [4:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [6:0] dig;
	logic [7:0] spc, src, per, duty;
	int miscompares, tests_run;
	gdc_regs dut_u (.CLK(clk), .RST(rst), .WB_ADR_I(adr), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(sel), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_ACK_O(ack), .WB_ERR_O(err),
		.LOOP_PRIMARY_PWM(lp), .LOOP_SECONDARY_PWM(ls),
		.OVERVOLT_ACTIVE(ov), .STEER_PWM(steer), .DIG_TEST_SIGNALS(dig),
		.PRIMARY_GATE_DRIVE(pg), .SECONDARY_GATE_DRIVE(sg),
		.SET_POINT_CODE(spc), .SECOND_REFERENCE_CODE(src),
		.REFERENCE_OUTPUT_ENABLE(refo), .SENSE_PIN_PULLUP_ENABLE(pull),
		.TEST_DIGITAL_VALUE(tval), .TEST_DIGITAL_ROUTE(tdr),
		.TEST_ANALOG_ROUTE(tar), .ANALOG_TEST_TO_ADC(tadc));
	gdc_loop_model model_u (.clk(clk), .rst(rst), .period(per), .duty(duty),
		.steer_pwm(steer));
	// 250 MHz
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic check(input string what, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Classic cycle: hold until ack or err is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] s, output logic [7:0] q, output logic e);
		int n;
		n = 0;
		{cyc, stb, we, sel, adr, wdat} <= {2'b11, w, s, a, 24'h000000, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
		q = rdat[7:0];
		e = err;
		check("bus answer", 1, n < 50);
		{cyc, stb} <= 2'b00;
		@(posedge clk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic e;
		wb(1'b1, a, d, 4'hF, q, e);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] x);
		logic [7:0] q;
		logic e;
		wb(1'b0, a, 8'h00, 4'hF, q, e);
		check("read", {1'b0, x}, {e, q});
	endtask
	// Sync plus gate stage settle well inside this
	task automatic settle;
		repeat (8) @(posedge clk);
	endtask
	task automatic t_regs;
		logic [4:0] a[6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14};
		logic [7:0] m[6] = '{8'hFF, 8'hFF, 8'hFF, 8'hF7, 8'hFB, 8'hE8};
		logic [7:0] q;
		logic e;
		for (int i = 0; i < 6; i++) begin
			rd(a[i], 8'h00);
			wr(a[i], 8'hFF);
			rd(a[i], m[i]);
		end
		check("codes", 16'hFFFF, {spc, src});
		wb(1'b1, 5'h04, 8'h12, 4'h0, q, e);
		rd(5'h04, 8'hFF);
		wb(1'b0, 5'h18, 8'h00, 4'hF, q, e);
		check("unmapped", 1, e);
		for (int i = 0; i < 6; i++)
			wr(a[i], 8'h00);
	endtask
	task automatic edge_time(input int d, input logic v, output int n);
		n = 0;
		if (d == 1)
			ls <= v;
		else
			lp <= v;
		do begin
			@(posedge clk);
			n++;
		end while ((d == 1 ? sg : pg) !== v && n < 300);
	endtask
	task automatic t_dead;
		int rb, fb, r, f;
		logic [3:0] c[3] = '{4'h0, 4'h7, 4'hF};
		for (int d = 0; d < 2; d++) begin
			wr(5'h0C, 8'hF0);
			edge_time(d, 1'b1, rb);
			edge_time(d, 1'b0, fb);
			check("bypass fall", rb, fb);
			for (int k = 0; k < 3; k++) begin
				wr(5'h00, {c[k], c[k]});
				wr(5'h0C, 8'hC0);
				edge_time(d, 1'b1, r);
				edge_time(d, 1'b0, f);
				check("rise", rb + (c[k] + 1) * DT_STEP_CYC - 1, r);
				check("fall", fb, f);
			end
		end
	endtask
	task automatic t_enable;
		logic [7:0] pe[3] = '{8'h30, 8'hB0, 8'h70};
		{lp, ls} <= 2'b11;
		for (int i = 0; i < 3; i++) begin
			wr(5'h0C, pe[i]);
			settle;
			check("gates", pe[i][7:6], {pg, sg});
		end
		{lp, ls} <= 2'b00;
	endtask
	// Desat output is outside this block and left off while steering
	task automatic t_steer;
		logic [11:0] t[5] = '{12'hF22, 12'hF10, 12'hF15, 12'hF36, 12'h020};
		per <= 8'h10;
		for (int i = 0; i < 5; i++) begin
			duty <= t[i][11] ? 8'hFF : 8'h00;
			ov <= t[i][2];
			wr(5'h0C, {4'hF, 2'b00, t[i][5:4]});
			settle;
			check("steer", t[i][1:0], {pg, sg});
		end
		ov <= 1'b0;
		wr(5'h0C, 8'h00);
	endtask
	task automatic t_misc;
		wr(5'h0C, 8'h04);
		settle;
		check("pullup", 1, pull);
		for (int m = 0; m < 4; m++) begin
			wr(5'h14, {m[1:0], 6'h00});
			settle;
			check("ref out", m == 1, refo);
		end
		wr(5'h10, 8'h01);
		settle;
		check("analog", 3'b011, {tdr, tar, tadc});
		for (int k = 0; k < 8; k++) begin
			wr(5'h10, {1'b1, k[2:0], 4'h1});
			dig <= (k == 7) ? 7'h7F : 7'h01 << k;
			settle;
			check("dig hi", {3'b100, k < 7}, {tdr, tar, tadc, tval});
			dig <= (k == 7) ? 7'h00 : ~(7'h01 << k);
			settle;
			check("dig lo", 0, tval);
		end
	endtask
	initial begin
		{rst, cyc, stb, we, lp, ls, ov} = 7'h40;
		{adr, sel, wdat, dig, per, duty} = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("reset outs", 0, {pg, sg, refo, pull, tdr, tar, tadc});
		t_regs;
		t_dead;
		t_enable;
		t_steer;
		t_misc;
		stop_test;
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		stop_test;
	end
endmodule
`default_nettype wire
